//--- rtl/esb_bridge.sv
`timescale 1ns/1ps
// Operation
// - system bus side always big_endian
// - core endianness selectable, little_endian at reset
// - pci byte-lane swap switchable by software
// - big_endian core passes data unchanged
// - address coherent passes whole words unchanged
// - address coherent redirects byte and half lanes
// - address coherent fetches match big_endian format
// - data coherent keeps bytes at same address
// - data coherent reverses bytes in words, halves
// - page attribute picks address or data coherence
// - swapping done here in the bridge
// - swap enable gates page attribute when little_endian
// - swap enable ignored in big_endian mode
// - attribute per 1-Mbyte page with every access
module esb_bridge (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // host core side
  input  wire logic                   core_big_endian,
  input  wire logic                   swap_en,
  input  wire logic                   core_valid,
  output wire logic                   core_ready,
  input  wire logic [esb_pkg::ESB_AW-1:0] core_addr,
  input  wire logic [esb_pkg::ESB_DW-1:0] core_wdata,
  input  wire esb_pkg::esb_size_e     core_size,
  input  wire logic                   core_write,
  input  wire logic                   core_page_attr,
  output logic                        core_rvalid,
  output logic [esb_pkg::ESB_DW-1:0]  core_rdata,
  // big_endian system bus side
  output wire logic                   sys_valid,
  input  wire logic                   sys_ready,
  output wire logic [esb_pkg::ESB_AW-1:0] sys_addr,
  output wire logic [esb_pkg::ESB_DW-1:0] sys_wdata,
  output wire esb_pkg::esb_size_e     sys_size,
  output wire logic                   sys_write,
  input  wire logic                   sys_rvalid,
  input  wire logic [esb_pkg::ESB_DW-1:0] sys_rdata,
  // pci byte-lane swap controls and status
  input  wire logic                   pci_addr_swap,
  input  wire logic                   pci_data_swap,
  input  wire logic                   pci_be_ctl,
  output logic                        pci_swap_active,
  output esb_pkg::esb_mode_e          cur_mode
);
  import esb_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta;                             // first stage, read only by rst_sync
  logic rst_sync;                             // released reset used everywhere

  // async assert, sync release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // control level synchronisers
  // ------------------------------------------------------------
  // the mode bits come from software pins outside this domain
  logic [4:0] ctl_meta;                       // first stage only
  logic [4:0] ctl_sync;                       // second stage, safe to read
  logic       big_q;                          // synchronised core endianness
  logic       swap_en_q;                      // synchronised swap enable

  // both stages come up at the little_endian software settings, so the
  // pci status cannot flash high for a cycle after reset release
  localparam logic [4:0] CTL_RST = {ESB_PCI_ADDR_SWAP_LE, ESB_PCI_DATA_SWAP_LE,
                                    ESB_PCI_BE_CTL, ESB_RST_SWAP_EN, ESB_RST_CORE_BIG};

  // two flops per control level, only the second one is read
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ctl_meta <= CTL_RST;
      ctl_sync <= CTL_RST;
    end else begin
      ctl_meta <= {pci_addr_swap, pci_data_swap, pci_be_ctl, swap_en, core_big_endian};
      ctl_sync <= ctl_meta;
    end
  end

  assign big_q     = ctl_sync[0];             // core comes up little_endian
  assign swap_en_q = ctl_sync[1];

  // pci swap is enabled by software through its own controls; the
  // bridge just reports it
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pci_swap_active <= 1'b0;
    end else begin
      pci_swap_active <= ctl_sync[4] && ctl_sync[3];
    end
  end

  // ------------------------------------------------------------
  // per-transaction mode selection
  // ------------------------------------------------------------
  // the page attribute travels with the access, one bit per 1-Mbyte
  // page decoded upstream
  esb_mode_e next_mode;

  always_comb begin
    if (big_q) begin
      next_mode = ESB_MODE_BIG;               // swap enable ignored
    end else if (swap_en_q && core_page_attr) begin
      next_mode = ESB_MODE_DATA;
    end else begin
      next_mode = ESB_MODE_ADDR;
    end
  end

  // ------------------------------------------------------------
  // conversion, done in the bridge so no processor adjusts
  // ------------------------------------------------------------
  function automatic logic [ESB_DW-1:0] swap_lanes(input logic [ESB_DW-1:0] d,
                                                   input esb_size_e sz);
    logic [ESB_DW-1:0] r;
    r = d;
    if (sz == ESB_SZ_WORD) begin
      r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end else if (sz == ESB_SZ_HALF) begin
      r = {d[23:16], d[31:24], d[7:0], d[15:8]};
    end
    return r;
  endfunction

  logic [ESB_AW-1:0] next_addr;               // redirected address
  logic [ESB_DW-1:0] next_wdata;              // converted write data

  always_comb begin
    next_addr  = core_addr;
    next_wdata = core_wdata;
    case (next_mode)
      ESB_MODE_ADDR: begin
        // words untouched, so instruction words keep their format,
        if (core_size == ESB_SZ_BYTE) begin
          next_addr[1:0] = ~core_addr[1:0];
        end else if (core_size == ESB_SZ_HALF) begin
          next_addr[1] = ~core_addr[1];
        end
      end
      ESB_MODE_DATA: begin
        next_wdata = swap_lanes(core_wdata, core_size);
      end
      default: begin
        next_addr  = core_addr;               // pass through
        next_wdata = core_wdata;
      end
    endcase
  end

  // ------------------------------------------------------------
  // request buffer toward the system bus
  // ------------------------------------------------------------
  esb_stream_if in_st ();
  esb_stream_if out_st ();

  // mode is stamped on each request as it enters
  assign in_st.valid      = core_valid;
  assign in_st.req.addr   = next_addr;
  assign in_st.req.wdata  = next_wdata;
  assign in_st.req.size   = core_size;
  assign in_st.req.write  = core_write;
  assign in_st.req.mode   = next_mode;
  assign core_ready       = in_st.ready;

  esb_skid_buf u_buf (
    .clk   (clk),
    .rst_n (rst_sync),
    .in_s  (in_st),
    .out_s (out_st)
  );

  // system bus sees only big_endian ordering
  assign sys_valid    = out_st.valid;
  assign out_st.ready = sys_ready;
  assign sys_addr     = out_st.req.addr;
  assign sys_wdata    = out_st.req.wdata;
  assign sys_size     = out_st.req.size;
  assign sys_write    = out_st.req.write;

  // ------------------------------------------------------------
  // read return path
  // ------------------------------------------------------------
  // reads come back in issue order; a small tag fifo keeps each read's
  // mode and size so a mode change in flight does no harm
  localparam int TQ = 4;
  logic [3:0]   tag_q [TQ];                   // {mode, size}
  logic [1:0]   tq_wr;
  logic [1:0]   tq_rd;
  logic         issue_rd;
  esb_mode_e    rd_mode;
  esb_size_e    rd_size;

  assign issue_rd = sys_valid && sys_ready && !sys_write;
  assign rd_mode  = esb_mode_e'(tag_q[tq_rd][3:2]);
  assign rd_size  = esb_size_e'(tag_q[tq_rd][1:0]);

  // tag storage; assumes no more than four reads outstanding
  always_ff @(posedge clk) begin
    if (issue_rd) begin
      tag_q[tq_wr] <= {out_st.req.mode, out_st.req.size};
    end
  end

  // tag pointers
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      tq_wr <= 2'd0;
      tq_rd <= 2'd0;
    end else begin
      if (issue_rd) begin
        tq_wr <= tq_wr + 2'd1;
      end
      if (sys_rvalid) begin
        tq_rd <= tq_rd + 2'd1;
      end
    end
  end

  // registered read data back to the core
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      core_rvalid <= 1'b0;
      core_rdata  <= 32'h0000_0000;
    end else begin
      core_rvalid <= sys_rvalid;
      if (sys_rvalid) begin
        if (rd_mode == ESB_MODE_DATA) begin
          core_rdata <= swap_lanes(sys_rdata, rd_size);
        end else begin
          core_rdata <= sys_rdata;
        end
      end
    end
  end

  // current mode for status
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      cur_mode <= ESB_MODE_ADDR;
    end else begin
      cur_mode <= next_mode;
    end
  end
endmodule

//--- rtl/esb_pkg.sv
package esb_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ESB_AW = 32;                 // host and system bus address width
  localparam int ESB_DW = 32;                 // data width, one word
  localparam int ESB_PAGE_LSB = 20;           // 1-Mbyte page boundary bit

  // access size encoding, as on the system bus
  typedef enum logic [1:0] {
    ESB_SZ_BYTE = 2'b00,
    ESB_SZ_HALF = 2'b01,
    ESB_SZ_WORD = 2'b10
  } esb_size_e;

  // conversion mode chosen per transaction
  typedef enum logic [1:0] {
    ESB_MODE_BIG  = 2'b00,                    // big_endian core, pass through
    ESB_MODE_ADDR = 2'b01,                    // little_endian address coherent
    ESB_MODE_DATA = 2'b10                     // little_endian data coherent
  } esb_mode_e;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic ESB_RST_CORE_BIG  = 1'b0;  // core comes up little_endian
  localparam logic ESB_RST_SWAP_EN   = 1'b0;  // swap enable clear after reset
  localparam logic ESB_PCI_ADDR_SWAP_LE = 1'b0;
  localparam logic ESB_PCI_DATA_SWAP_LE = 1'b0;
  localparam logic ESB_PCI_BE_CTL       = 1'b1;

  // one buffered transaction
  typedef struct packed {
    logic [ESB_AW-1:0] addr;
    logic [ESB_DW-1:0] wdata;
    esb_size_e         size;
    logic              write;
    esb_mode_e         mode;
  } esb_req_s;
endpackage

//--- rtl/esb_skid_buf.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-entry buffer: a stall by the system bus loses no request
// ------------------------------------------------------------
module esb_skid_buf (
  input wire logic clk,
  input wire logic rst_n,
  esb_stream_if.dst in_s,
  esb_stream_if.src out_s
);
  import esb_pkg::*;

  esb_req_s   mem [2];                        // two storage slots
  logic       wr_ptr;                         // next slot to fill
  logic       rd_ptr;                         // oldest slot
  logic [1:0] count;                          // slots in use
  logic       push;
  logic       pop;

  // full only at two entries, so ready is honest
  assign in_s.ready  = (count != 2'd2);
  assign out_s.valid = (count != 2'd0);
  assign out_s.req   = mem[rd_ptr];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // storage, written only on a push
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_s.req;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- rtl/esb_stream_if.sv
`timescale 1ns/1ps
// valid/ready carrier for one converted request
interface esb_stream_if;
  import esb_pkg::*;
  logic     valid;                            // request present
  logic     ready;                            // taker can accept
  esb_req_s req;                              // request payload
  modport src (output valid, output req, input ready);
  modport dst (input valid, input req, output ready);
endinterface

//--- sim/esb_bridge_assertions.sv
`timescale 1ns/1ps
module esb_chk (
  input wire logic                        clk,
  input wire logic                        rstn,
  input wire logic                        core_big_endian,
  input wire logic                        swap_en,
  input wire logic                        core_valid,
  input wire logic                        core_ready,
  input wire logic [31:0]                 core_addr,
  input wire logic [31:0]                 core_wdata,
  input wire esb_pkg::esb_size_e          core_size,
  input wire logic                        core_page_attr,
  input wire logic                        core_rvalid,
  input wire logic                        sys_valid,
  input wire logic                        sys_ready,
  input wire logic [31:0]                 sys_addr,
  input wire logic [31:0]                 sys_wdata,
  input wire logic                        sys_rvalid
);
  import esb_pkg::*;
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  logic [2:0]  stab;     // cycles since mode inputs last moved
  logic [1:0]  lvl;      // mode levels watched for change
  logic [1:0]  lvl_q;    // mode levels one cycle ago
  logic        le_addr;  // little_endian, address coherent
  logic        le_data;  // little_endian, data coherent
  logic [31:0] rev_w;    // word with its bytes reversed
  logic [31:0] rev_h;    // bytes swapped inside each half
  logic [31:0] addr_q;   // core address one cycle ago
  logic [31:0] data_q;   // core write data one cycle ago
  logic [31:0] rev_w_q;  // reversed word one cycle ago
  logic [31:0] rev_h_q;  // half-swapped word one cycle ago
  logic        keep_ad;  // bus shows last cycle's address and data
  assign lvl = {core_big_endian, swap_en};
  assign le_addr = !core_big_endian && !(swap_en && core_page_attr);
  assign le_data = !core_big_endian && swap_en && core_page_attr;
  assign rev_w = {core_wdata[7:0], core_wdata[15:8], core_wdata[23:16], core_wdata[31:24]};
  assign rev_h = {core_wdata[23:16], core_wdata[31:24], core_wdata[7:0], core_wdata[15:8]};
  assign keep_ad = (sys_addr == addr_q) && (sys_wdata == data_q);
  // last cycle's request, the reference for what the bus shows now
  always_ff @(posedge clk) begin
    addr_q  <= core_addr;
    data_q  <= core_wdata;
    rev_w_q <= rev_w;
    rev_h_q <= rev_h;
    lvl_q   <= lvl;
  end
  // the mode inputs pass a synchroniser, so only judge settled modes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stab <= 3'h0;
    end else if (lvl != lvl_q) begin
      stab <= 3'h0;
    end else if (stab != 3'h7) begin
      stab <= stab + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  // request taken into an empty buffer while the modes are settled
  sequence s_take;
    core_valid && core_ready && !sys_valid && (stab == 3'h7);
  endsequence
  // the same take in address coherent mode
  sequence s_addr_take;
    s_take ##0 le_addr;
  endsequence
  // the same take in data coherent mode
  sequence s_data_take;
    s_take ##0 le_data;
  endsequence
  // ------------------------------------------------------------
  // conversion and flow
  // ------------------------------------------------------------
  a_big_pass: assert property (
    s_take ##0 core_big_endian |=> sys_valid && keep_ad)
    else $error("big mode altered");
  a_word_keep: assert property (
    s_addr_take ##0 (core_size == ESB_SZ_WORD) |=> keep_ad)
    else $error("word changed");
  a_byte_flip: assert property (
    s_addr_take ##0 (core_size == ESB_SZ_BYTE)
      |=> (sys_addr == (addr_q ^ 32'h0000_0003)) && (sys_wdata == data_q))
    else $error("byte lane wrong");
  a_half_flip: assert property (
    s_addr_take ##0 (core_size == ESB_SZ_HALF)
      |=> (sys_addr == (addr_q ^ 32'h0000_0002)) && (sys_wdata == data_q))
    else $error("half lane wrong");
  a_word_rev: assert property (
    s_data_take ##0 (core_size == ESB_SZ_WORD)
      |=> (sys_addr == addr_q) && (sys_wdata == rev_w_q))
    else $error("word not reversed");
  a_half_rev: assert property (
    s_data_take ##0 (core_size == ESB_SZ_HALF)
      |=> (sys_addr == addr_q) && (sys_wdata == rev_h_q))
    else $error("half not reversed");
  a_byte_same: assert property (
    s_data_take ##0 (core_size == ESB_SZ_BYTE) |=> keep_ad)
    else $error("byte moved");
  a_stall_hold: assert property (
    sys_valid && !sys_ready |=> sys_valid && $stable(sys_addr) && $stable(sys_wdata))
    else $error("stalled request moved");
  a_rd_return: assert property (
    sys_rvalid |=> core_rvalid)
    else $error("read return lost");
endmodule
bind esb_bridge esb_chk u_chk (.clk(clk), .rstn(rstn), .core_big_endian(core_big_endian),
  .swap_en(swap_en), .core_valid(core_valid), .core_ready(core_ready), .core_addr(core_addr),
  .core_wdata(core_wdata), .core_size(core_size), .core_page_attr(core_page_attr),
  .core_rvalid(core_rvalid), .sys_valid(sys_valid), .sys_ready(sys_ready),
  .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_rvalid(sys_rvalid));

//--- sim/esb_bus_model.sv
`timescale 1ns/1ps
// big_endian system bus: stalls on demand, answers reads late
module esb_bus_model #(parameter logic [31:0] RD_BASE = 32'h1122_3344) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        stall,
  input  wire logic        sys_valid,
  input  wire logic        sys_write,
  input  wire logic [31:0] sys_addr,
  output wire logic        sys_ready,
  output logic             sys_rvalid,
  output logic [31:0]      sys_rdata
);
  logic [1:0]  rd_pipe;  // read return delay line
  logic [31:0] rd_addr;  // address of the last accepted transfer
  assign sys_ready = !stall;
  // data is never swapped here, the bus side is fixed big_endian
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_pipe <= 2'h0;
      rd_addr <= 32'h0000_0000;
      sys_rvalid <= 1'b0;
      sys_rdata <= 32'h0000_0000;
    end else begin
      rd_pipe <= {rd_pipe[0], sys_valid && sys_ready && !sys_write};
      if (sys_valid && sys_ready) rd_addr <= sys_addr;
      sys_rvalid <= rd_pipe[1];
      // idle data toggles so a stale sample never looks right
      sys_rdata <= rd_pipe[1] ? (RD_BASE ^ rd_addr) : ~sys_rdata;
    end
  end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import esb_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, core_big_endian = 1'b0, swap_en = 1'b0, stall = 1'b0;
  logic core_valid = 1'b0, core_write = 1'b0, core_page_attr = 1'b0;
  logic pci_a = 1'b0, pci_d = 1'b0, pci_b = 1'b1;
  logic [31:0] core_addr = 32'h0000_0000, core_wdata = 32'h0000_0000;
  esb_size_e core_size = ESB_SZ_WORD;
  logic core_ready, core_rvalid, sys_valid, sys_ready, sys_write, sys_rvalid, pci_act;
  logic [31:0] core_rdata, sys_addr, sys_wdata, sys_rdata;
  esb_size_e sys_size;
  esb_mode_e cur_mode;
  logic [66:0] q[$];  // transfers seen on the bus: write, size, address, data
  int n_errors = 0, checked = 0, cycles = 0;
  always #2.5 clk = ~clk;
  esb_bridge dut (.clk(clk), .rstn(rstn), .core_big_endian(core_big_endian), .swap_en(swap_en),
    .core_valid(core_valid), .core_ready(core_ready), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_size(core_size), .core_write(core_write),
    .core_page_attr(core_page_attr), .core_rvalid(core_rvalid), .core_rdata(core_rdata),
    .sys_valid(sys_valid), .sys_ready(sys_ready), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
    .sys_size(sys_size), .sys_write(sys_write), .sys_rvalid(sys_rvalid), .sys_rdata(sys_rdata),
    .pci_addr_swap(pci_a), .pci_data_swap(pci_d), .pci_be_ctl(pci_b),
    .pci_swap_active(pci_act), .cur_mode(cur_mode));
  esb_bus_model u_bus (.clk(clk), .rstn(rstn), .stall(stall), .sys_valid(sys_valid),
    .sys_write(sys_write), .sys_addr(sys_addr), .sys_ready(sys_ready),
    .sys_rvalid(sys_rvalid), .sys_rdata(sys_rdata));
  // log every accepted bus transfer
  always @(posedge clk) begin
    if (sys_valid && sys_ready) q.push_back({sys_write, sys_size, sys_addr, sys_wdata});
  end
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  // request stays up until taken; caller drops valid
  task automatic put(input logic [31:0] a, d, input esb_size_e sz, input logic w, pa);
    core_addr <= a;
    core_wdata <= d;
    core_size <= sz;
    core_write <= w;
    core_page_attr <= pa;
    core_valid <= 1'b1;
    @(posedge clk);
    while (!core_ready) @(posedge clk);
  endtask
  task automatic got(input logic [31:0] ea, ed, input esb_size_e sz);
    logic [66:0] e;
    while (q.size() == 0) @(posedge clk);
    e = q.pop_front();
    chk(e[63:32], ea);
    chk(e[31:0], ed);
    chk({29'h0, e[66:64]}, {29'h0, 1'b1, sz});
  endtask
  task automatic wr(input logic [31:0] a, d, input esb_size_e sz, input logic pa,
                    input logic [31:0] ea, ed);
    put(a, d, sz, 1'b1, pa);
    core_valid <= 1'b0;
    got(ea, ed, sz);
  endtask
  task automatic rd(input logic pa, input esb_size_e sz, input logic [31:0] e);
    put(32'h0000_0200, 32'h0000_0000, sz, 1'b0, pa);
    core_valid <= 1'b0;
    while (!core_rvalid) @(posedge clk);
    chk(core_rdata, e);
    q.delete();
  endtask
  // mode inputs are synchronised, give them time to land
  task automatic setm(input logic b, s);
    core_big_endian <= b;
    swap_en <= s;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    chk({30'h0, cur_mode}, 32'h0000_0001);
    wr(32'h0000_0100, 32'h1122_3344, ESB_SZ_BYTE, 1'b1, 32'h0000_0103, 32'h1122_3344);
    wr(32'h0000_0102, 32'h1122_3344, ESB_SZ_HALF, 1'b1, 32'h0000_0100, 32'h1122_3344);
    wr(32'h0000_0104, 32'h1122_3344, ESB_SZ_WORD, 1'b1, 32'h0000_0104, 32'h1122_3344);
    rd(1'b0, ESB_SZ_WORD, 32'h1122_3144);
    rd(1'b0, ESB_SZ_BYTE, 32'h1122_3147);
    setm(1'b0, 1'b1);
    wr(32'h0000_0108, 32'h1122_3344, ESB_SZ_WORD, 1'b1, 32'h0000_0108, 32'h4433_2211);
    wr(32'h0000_010a, 32'h1122_3344, ESB_SZ_HALF, 1'b1, 32'h0000_010a, 32'h2211_4433);
    wr(32'h0000_0109, 32'h1122_3344, ESB_SZ_BYTE, 1'b1, 32'h0000_0109, 32'h1122_3344);
    wr(32'h0000_0109, 32'h1122_3344, ESB_SZ_BYTE, 1'b0, 32'h0000_010a, 32'h1122_3344);
    rd(1'b1, ESB_SZ_WORD, 32'h4431_2211);
    rd(1'b1, ESB_SZ_HALF, 32'h2211_4431);
    chk({30'h0, cur_mode}, 32'h0000_0002);
    setm(1'b1, 1'b1);
    chk({30'h0, cur_mode}, 32'h0000_0000);
    wr(32'h0000_0101, 32'h1122_3344, ESB_SZ_BYTE, 1'b1, 32'h0000_0101, 32'h1122_3344);
    rd(1'b1, ESB_SZ_WORD, 32'h1122_3144);
    stall <= 1'b1;
    put(32'h0000_0300, 32'h0000_0001, ESB_SZ_WORD, 1'b1, 1'b0);
    put(32'h0000_0304, 32'h0000_0002, ESB_SZ_WORD, 1'b1, 1'b0);
    core_valid <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, core_ready}, 32'h0000_0000);
    stall <= 1'b0;
    got(32'h0000_0300, 32'h0000_0001, ESB_SZ_WORD);
    got(32'h0000_0304, 32'h0000_0002, ESB_SZ_WORD);
    pci_a <= 1'b1;
    pci_d <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, pci_act}, 32'h0000_0001);
    pci_a <= 1'b0;
    pci_d <= 1'b0;
    repeat (8) @(posedge clk);
    chk({31'h0, pci_act}, 32'h0000_0000);
    stop_test();
  end
endmodule
